/* File: phy_cfg_pkg.sv */
package phy_cfg_pkg;
	// management register map
	localparam logic [4:0] FX_CTRL_ADDR = 5'h12;
	localparam int FX_ACT_BIT = 15;
	localparam int FX_ALL_BIT = 11;
	localparam int FX_SEL_LSB = 8;
	localparam int FX_SEL_MSB = 10;
	localparam int FX_MODE_LSB = 0;
	localparam int FX_MODE_MSB = 7;
	localparam logic [15:0] FX_CTRL_RESET = 16'h0000;
	localparam logic [15:0] FX_CTRL_RW_MASK = 16'h8FFF;
	localparam logic [7:0] FX_MODE_NONE = 8'h00;
	localparam logic [7:0] FX_MODE_FX = 8'h01;
	localparam logic [7:0] FX_PORTS_RESET = 8'h00;
	// strap layout
	localparam int NUM_PORTS = 8;
	localparam int NUM_STRAPS = 8;
	localparam int STRAP_BITS = 4;
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// speed and duplex strap codes
	localparam logic [1:0] SD_ALL = 2'h0;
	localparam logic [1:0] SD_FDX_MOSTLY = 2'h1;
	localparam logic [1:0] SD_GIG_FDX = 2'h2;
	localparam logic [1:0] SD_FAST_ONLY = 2'h3;
	// advertisement patterns: {100fdx,100hdx,10fdx,10hdx} and {1000fdx,1000hdx}
	localparam logic [3:0] ADV_FAST_ALL = 4'hF;
	localparam logic [3:0] ADV_FAST_NONE = 4'h0;
	localparam logic [1:0] ADV_GIG_ALL = 2'h3;
	localparam logic [1:0] ADV_GIG_FDX = 2'h2;
	localparam logic [1:0] ADV_GIG_NONE = 2'h0;
	// LED timing: slowest stretch, faster codes halve it
	localparam int CLK_HZ = 10_000_000;
	localparam int LED_STRETCH_MS = 400;
	localparam int LED_HALF_CYCLES = (CLK_HZ / 1000) * LED_STRETCH_MS / 2;
	localparam logic [20:0] LED_CNT_ZERO = 21'h00_0000;

	typedef struct packed {
		logic downshift_en;
		logic [3:0] adv_fast;
		logic [1:0] adv_gig;
		logic mac_aneg_en;
		logic power_saving_mode_en;
		logic adv_asym_pause;
		logic adv_sym_pause;
		logic [2:0] media_if;
		logic signal_detect_input_active_low;
		logic ref_clk_156;
		logic clock_output_pin_en;
		logic led_combine_off;
		logic [1:0] led_rate;
		logic addr_reverse;
		logic [1:0] phy_addr_hi;
		logic [3:0] led_status_only;
		logic [7:0] led_func;
	} strap_cfg_s;
endpackage

/* File: strap_sync.sv */
`timescale 1ns/1ns
// three-stage synchroniser; a bit moves only once stages two and three agree
module strap_sync (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [31:0] pins_i,
	output logic [31:0] stable_o
);
	logic [31:0] s1;
	logic [31:0] s2;
	logic [31:0] s3;

	// shift chain; s1 only feeds s2
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s1 <= 32'h0000_0000;
			s2 <= 32'h0000_0000;
			s3 <= 32'h0000_0000;
		end else begin
			s1 <= pins_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// bits that disagree keep their old value, filtering single-cycle glitches
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			stable_o <= 32'h0000_0000;
		end else begin
			stable_o <= (s2 & ~(s2 ^ s3)) | (stable_o & (s2 ^ s3));
		end
	end
endmodule // strap_sync

/* File: phy_strap_and_fx_config.sv */
`timescale 1ns/1ns
module phy_strap_and_fx_config #(
	parameter int LED_HALF_CYCLES = phy_cfg_pkg::LED_HALF_CYCLES
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [31:0] config_strap_pins_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [15:0] reg_rdata_o,
	output logic [7:0] fx_mode_o,
	output phy_cfg_pkg::strap_cfg_s strap_cfg_o,
	output logic strap_done_o,
	output logic [39:0] port_addr_o,
	output logic led_blink_o
);
	logic [15:0] fx_ctrl;
	logic [31:0] strap_stable;
	logic [2:0] settle_cnt;
	logic [20:0] led_cnt;
	logic [20:0] led_half;
	logic fx_wr;
	logic [7:0] fx_mode_w;
	logic [2:0] fx_sel_w;

	// speed/duplex code to fast ethernet advertisement bits
	function automatic logic [3:0] adv_fast_of(input logic [1:0] code);
		case (code)
			phy_cfg_pkg::SD_GIG_FDX: adv_fast_of = phy_cfg_pkg::ADV_FAST_NONE;
			default: adv_fast_of = phy_cfg_pkg::ADV_FAST_ALL;
		endcase
	endfunction

	// speed/duplex code to gigabit advertisement bits
	function automatic logic [1:0] adv_gig_of(input logic [1:0] code);
		case (code)
			phy_cfg_pkg::SD_ALL: adv_gig_of = phy_cfg_pkg::ADV_GIG_ALL;
			phy_cfg_pkg::SD_FDX_MOSTLY: adv_gig_of = phy_cfg_pkg::ADV_GIG_FDX;
			phy_cfg_pkg::SD_GIG_FDX: adv_gig_of = phy_cfg_pkg::ADV_GIG_FDX;
			default: adv_gig_of = phy_cfg_pkg::ADV_GIG_NONE;
		endcase
	endfunction

	// new per-port fiber state; reserved mode codes leave the port alone
	function automatic logic fx_next(input logic cur, input logic [7:0] mode);
		if (mode == phy_cfg_pkg::FX_MODE_FX) begin
			fx_next = 1'b1;
		end else if (mode == phy_cfg_pkg::FX_MODE_NONE) begin
			fx_next = 1'b0;
		end else begin
			fx_next = cur;
		end
	endfunction

	assign fx_wr = reg_we_i && (reg_addr_i == phy_cfg_pkg::FX_CTRL_ADDR);
	assign fx_mode_w = reg_wdata_i[phy_cfg_pkg::FX_MODE_MSB:phy_cfg_pkg::FX_MODE_LSB];
	assign fx_sel_w = reg_wdata_i[phy_cfg_pkg::FX_SEL_MSB:phy_cfg_pkg::FX_SEL_LSB];

	// fiber control register storage
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fx_ctrl <= phy_cfg_pkg::FX_CTRL_RESET;
		end else if (fx_wr) begin
			fx_ctrl <= reg_wdata_i & phy_cfg_pkg::FX_CTRL_RW_MASK;
		end
	end

	// registered read; unmapped addresses read zero
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_re_i && reg_addr_i == phy_cfg_pkg::FX_CTRL_ADDR) begin
			reg_rdata_o <= fx_ctrl;
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// activation uses the fields of the very write that sets the trigger,
	// so one write both loads and applies; the host need not clear it between runs
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fx_mode_o <= phy_cfg_pkg::FX_PORTS_RESET;
		end else if (fx_wr && reg_wdata_i[phy_cfg_pkg::FX_ACT_BIT]) begin
			for (int p = 0; p < phy_cfg_pkg::NUM_PORTS; p++) begin
				if (reg_wdata_i[phy_cfg_pkg::FX_ALL_BIT]) begin
					fx_mode_o[p] <= fx_next(fx_mode_o[p], fx_mode_w);
				end else if (fx_sel_w == p[2:0]) begin
					fx_mode_o[p] <= fx_next(fx_mode_o[p], fx_mode_w);
				end
			end
		end
	end

	strap_sync u_strap_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.pins_i(config_strap_pins_i),
		.stable_o(strap_stable)
	);

	// wait for the synchroniser to fill before trusting the straps
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			settle_cnt <= 3'h0;
		end else if (settle_cnt != phy_cfg_pkg::STRAP_SETTLE) begin
			settle_cnt <= settle_cnt + 3'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			strap_done_o <= 1'b0;
		end else if (settle_cnt == phy_cfg_pkg::STRAP_SETTLE) begin
			strap_done_o <= 1'b1;
		end
	end

	// decode the straps into defaults; pin n holds bits [4n+3:4n]
	// four bits a pin
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			strap_cfg_o <= '0;
		end else if (settle_cnt == phy_cfg_pkg::STRAP_SETTLE && !strap_done_o) begin
			strap_cfg_o.downshift_en <= strap_stable[30];
			strap_cfg_o.adv_fast <= adv_fast_of(strap_stable[29:28]);
			strap_cfg_o.adv_gig <= adv_gig_of(strap_stable[29:28]);
			strap_cfg_o.mac_aneg_en <= strap_stable[27];
			strap_cfg_o.power_saving_mode_en <= strap_stable[26];
			strap_cfg_o.adv_asym_pause <= strap_stable[25];
			strap_cfg_o.adv_sym_pause <= strap_stable[24];
			strap_cfg_o.media_if <= {strap_stable[23], strap_stable[19], strap_stable[15]};
			strap_cfg_o.signal_detect_input_active_low <= strap_stable[22];
			strap_cfg_o.ref_clk_156 <= strap_stable[21];
			strap_cfg_o.clock_output_pin_en <= strap_stable[20];
			strap_cfg_o.led_combine_off <= strap_stable[18];
			strap_cfg_o.led_rate <= strap_stable[17:16];
			strap_cfg_o.addr_reverse <= strap_stable[11];
			strap_cfg_o.phy_addr_hi <= {strap_stable[7], strap_stable[3]};
			strap_cfg_o.led_status_only <= {strap_stable[14], strap_stable[10],
				strap_stable[6], strap_stable[2]};
			strap_cfg_o.led_func <= {strap_stable[13:12], strap_stable[9:8],
				strap_stable[5:4], strap_stable[1:0]};
		end
	end

	// per-port management address, 5 bits each, port 0 in the low bits
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			port_addr_o <= '0;
		end else if (settle_cnt == phy_cfg_pkg::STRAP_SETTLE && !strap_done_o) begin
			for (int p = 0; p < phy_cfg_pkg::NUM_PORTS; p++) begin
				port_addr_o[5*p +: 5] <= {strap_stable[7], strap_stable[3],
					strap_stable[11] ? 3'(7 - p) : 3'(p)};
			end
		end
	end

	// blink half period halves per code step
	assign led_half = 21'(LED_HALF_CYCLES) >> strap_cfg_o.led_rate;

	// LED blink divider; toggles every half period of the chosen rate
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			led_cnt <= phy_cfg_pkg::LED_CNT_ZERO;
			led_blink_o <= 1'b0;
		end else if (led_cnt + 21'h1 >= led_half) begin
			led_cnt <= phy_cfg_pkg::LED_CNT_ZERO;
			led_blink_o <= ~led_blink_o;
		end else begin
			led_cnt <= led_cnt + 21'h1;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	a_reserved_read_zero: assert property (
		reg_re_i && reg_addr_i == phy_cfg_pkg::FX_CTRL_ADDR |=> reg_rdata_o[14:12] == 3'h0)
		else $error("reserved fiber control bits read nonzero");
	a_zero_trigger_idle: assert property (
		fx_wr && !reg_wdata_i[15] |=> $stable(fx_mode_o))
		else $error("fiber state changed without trigger");
	a_all_ports_fx: assert property (
		fx_wr && reg_wdata_i[15] && reg_wdata_i[11] && reg_wdata_i[7:0] == 8'h01
		|=> fx_mode_o == 8'hFF)
		else $error("all-ports activation missed a port");
	a_single_port_fx: assert property (
		fx_wr && reg_wdata_i[15] && !reg_wdata_i[11] && reg_wdata_i[7:0] == 8'h01
		|=> fx_mode_o == ($past(fx_mode_o) | (8'h01 << $past(reg_wdata_i[10:8]))))
		else $error("single port activation wrong");
	a_reserved_mode_hold: assert property (
		fx_wr && reg_wdata_i[15] && reg_wdata_i[7:1] != 7'h00 |=> $stable(fx_mode_o))
		else $error("reserved mode changed fiber state");
	a_strap_held: assert property (
		strap_done_o |=> $stable(strap_cfg_o) && $stable(port_addr_o))
		else $error("strap defaults changed after sampling");
	a_strap_latency: assert property (
		$fell(srst_i) |-> ##[4:6] strap_done_o)
		else $error("straps not sampled in time");
	a_addr_top_bits: assert property (
		strap_done_o |-> port_addr_o[4:3] == strap_cfg_o.phy_addr_hi)
		else $error("address top bits mismatch");
	a_addr_reversal: assert property (
		strap_done_o |-> port_addr_o[2:0] == (strap_cfg_o.addr_reverse ? 3'h7 : 3'h0))
		else $error("port 0 address wrong for reversal setting");
	a_fast_only_speed: assert property (
		strap_done_o && strap_cfg_o.adv_gig == 2'h0 |-> strap_cfg_o.adv_fast == 4'hF)
		else $error("fast-only code lost fast advertisement");

	c_all_ports: cover property (fx_wr && reg_wdata_i[15] && reg_wdata_i[11]);
	c_single_port: cover property (fx_wr && reg_wdata_i[15] && !reg_wdata_i[11]);
	c_reversed: cover property (strap_done_o && strap_cfg_o.addr_reverse);
	c_blink: cover property ($changed(led_blink_o));
endmodule // phy_strap_and_fx_config

/* File: strap_board.sv */
`timescale 1ns/1ns
// board strap wiring: straps are static resistors, so the level simply stands
module strap_board (
	input wire logic [31:0] want_i,
	output logic [31:0] pins_o
);
	// reserved strap low
	// pin 7 bit 3 is always strapped to logic 0, whatever the bench asks for
	assign pins_o = {1'b0, want_i[30:0]};
endmodule // strap_board

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
	localparam int HALF = 16;
	logic mclk_i, srst_i, reg_we_i, reg_re_i;
	logic [4:0] reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, rd;
	logic [31:0] want, pins;
	logic [7:0] fx_mode_o;
	phy_cfg_pkg::strap_cfg_s strap_cfg_o;
	logic strap_done_o, led_blink_o;
	logic [39:0] port_addr_o;
	int errors = 0;
	int cmp_count = 0;

	strap_board i_board (.want_i(want), .pins_o(pins));
	phy_strap_and_fx_config #(.LED_HALF_CYCLES(HALF)) i_dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .config_strap_pins_i(pins),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .fx_mode_o(fx_mode_o),
		.strap_cfg_o(strap_cfg_o), .strap_done_o(strap_done_o),
		.port_addr_o(port_addr_o), .led_blink_o(led_blink_o));

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task automatic hang(input string what);
		check(64'h0000_0000_0000_0000, 64'h0000_0000_0000_0001, what);
		report_and_stop();
	endtask

	// host side: strobes change on the falling edge and last one cycle
	task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_we_i = 1'b1;
		@(negedge mclk_i);
		reg_we_i = 1'b0;
		@(negedge mclk_i);
	endtask

	task automatic reg_read(input logic [4:0] a);
		reg_addr_i = a;
		reg_re_i = 1'b1;
		@(negedge mclk_i);
		reg_re_i = 1'b0;
		rd = reg_rdata_o;
	endtask

	// strap pattern: code i drives speed code, led rate and address reversal
	function automatic logic [31:0] pins_for(input int i);
		logic [3:0] c;
		c = 4'h4 | 4'(i);
		return {c, 4'hA, 4'hB, c, 4'h9, (i % 2 == 1) ? 4'hE : 4'h6, 4'h3, 4'hC};
	endfunction

	function automatic phy_cfg_pkg::strap_cfg_s exp_cfg(input int i);
		phy_cfg_pkg::strap_cfg_s e;
		e = {1'b1, (i == 2) ? 4'h0 : 4'hF, (i != 3), (i == 0), 4'b1010, 3'b101,
			3'b011, 1'b1, 2'(i), (i % 2 == 1), 2'b01, 4'b0101, 8'b0110_1100};
		return e;
	endfunction

	// reset with the given straps, then judge decode, timing, addresses, LED rate
	task automatic strap_case(input int i);
		int n;
		logic v;
		want = pins_for(i);
		srst_i = 1'b1;
		repeat (10) @(negedge mclk_i);
		srst_i = 1'b0;
		n = 0;
		while (strap_done_o !== 1'b1) begin
			@(posedge mclk_i);
			#1;
			n++;
			if (n > 20) hang("strap done");
		end
		check(n, 5, "strap sample edge");
		check(strap_cfg_o, exp_cfg(i), "strap decode");
		for (int p = 0; p < 8; p++) begin
			check(port_addr_o[5*p +: 5], {2'b01, 3'((i % 2 == 1) ? 7 - p : p)}, "port addr");
		end
		// straps move on the falling edge like every other input
		@(negedge mclk_i);
		want = ~want;
		repeat (8) @(negedge mclk_i);
		check(strap_cfg_o, exp_cfg(i), "late pin change");
		v = led_blink_o;
		n = 0;
		while (led_blink_o === v) begin
			@(posedge mclk_i);
			#1;
			n++;
			if (n > 200) hang("led toggle");
		end
		v = led_blink_o;
		n = 0;
		while (led_blink_o === v && n < 200) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		check(n, HALF >> i, "led half period");
		@(negedge mclk_i);
	endtask

	// register path: reset value, both activation styles, reserved codes and bits
	task automatic fx_case();
		reg_read(5'h12);
		check(rd, phy_cfg_pkg::FX_CTRL_RESET, "fx reset");
		reg_write(5'h12, 16'h0801);
		check(fx_mode_o, 8'h00, "no trigger");
		reg_write(5'h12, 16'h8801);
		check(fx_mode_o, 8'hFF, "all ports");
		reg_read(5'h12);
		check(rd, 16'h8801, "readback");
		reg_write(5'h12, 16'h0800);
		reg_write(5'h12, 16'h8800);
		check(fx_mode_o, 8'h00, "all cleared");
		// one PHY at a time, trigger dropped before each new activation
		for (int p = 2; p < 8; p += 3) begin
			reg_write(5'h12, {5'h00, 3'(p), 8'h01});
			reg_write(5'h12, {5'h10, 3'(p), 8'h01});
		end
		check(fx_mode_o, 8'h24, "single ports");
		reg_write(5'h12, 16'h8302);
		check(fx_mode_o, 8'h24, "reserved mode");
		reg_write(5'h12, 16'h8500);
		check(fx_mode_o, 8'h04, "single clear");
		reg_write(5'h12, 16'hF000);
		reg_read(5'h12);
		check(rd, 16'h8000, "reserved bits");
		reg_write(5'h11, 16'h8801);
		check(fx_mode_o, 8'h04, "unmapped write");
		reg_read(5'h11);
		check(rd, 16'h0000, "unmapped read");
	endtask

	initial begin
		srst_i = 1'b1;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		reg_addr_i = 5'h00;
		reg_wdata_i = 16'h0000;
		want = 32'h0000_0000;
		@(negedge mclk_i);
		// every speed code and LED rate, reversal on and off
		for (int i = 0; i < 4; i++) begin
			strap_case(i);
		end
		fx_case();
		report_and_stop();
	end
endmodule // testbench
